// ===== psc_strap_decoder.v
// Strap-pin configuration front end with an Avalon-MM register slave
//
// Summary of operation
// - Result readout path independent of control path
// - Sample control-select strap at power-up
// - Serial mode accepts three- or four-wire SPI
// - Output layout chosen by layout straps
// - Per-channel lanes or time-multiplexed shared lanes
// - Known configuration after power-up and reset; resync needed after fault
// - Pin mode enables analog precharge buffers
// - Pin mode disables reference precharge buffers
// - Filter strap high sinc5, low wideband
// - Decimation straps 00/01/10/11 give 32/64/128/1024
// - One decimation ratio for all channels
`timescale 1ns/1ns
`default_nettype none
`include "psc_map.vh"
module psc_strap_decoder (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire ctrl_select_strap_in,
  input wire filter_strap_in,
  input wire decimation_strap_hi_in,
  input wire decimation_strap_lo_in,
  input wire output_layout_strap_hi_in,
  input wire output_layout_strap_lo_in,
  input wire start_n_in,
  input wire sync_n_in,
  input wire supply_fault_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg spi_mode_out,
  output reg spi_four_wire_out,
  output reg sinc5_sel_out,
  output reg [1:0] dec_sel_out,
  output reg [10:0] dec_ratio_out,
  output reg [1:0] lane_layout_out,
  output reg shared_lanes_out,
  output reg ain_precharge_en_out,
  output reg ref_precharge_en_out,
  output reg cfg_apply_out,
  output reg cfg_valid_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ACK = 3'b010;
  localparam ST_DONE = 3'b100;

  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;
  wire [7:0] pins_s;
  reg boot_r;
  reg [3:0] settle_r;
  reg [31:0] ctrl_r;
  reg reset_seen_r;
  reg need_sync_r;
  reg sync_prev_r;
  reg sync_req_r;
  reg [15:0] sync_cnt_r;
  reg [2:0] bus_st_r;
  reg [2:0] bus_st_nxt;
  reg [31:0] rdata_nxt;
  reg [5:0] straps_prev_r;
  wire sync_level;
  wire sync_edge;
  wire fault_s;
  wire straps_changed;
  wire sw_reset;

  function [10:0] dec_ratio;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: dec_ratio = `PSC_RATIO_00;
        2'b01: dec_ratio = `PSC_RATIO_01;
        2'b10: dec_ratio = `PSC_RATIO_10;
        default: dec_ratio = `PSC_RATIO_11;
      endcase
    end
  endfunction

  // Reset release through two flops so all logic leaves reset together
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  psc_sync2 #(
    .W(8)
  ) u_pins (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .async_in({supply_fault_in, ~start_n_in, ~sync_n_in,
      ctrl_select_strap_in, filter_strap_in,
      decimation_strap_hi_in, decimation_strap_lo_in,
      output_layout_strap_hi_in ^ output_layout_strap_lo_in ^ 1'b0}),
    .sync_out(pins_s)
  );

  // Layout straps take their own pair of synchronised flops
  wire [1:0] layout_s;
  psc_sync2 #(
    .W(2)
  ) u_layout (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .async_in({output_layout_strap_hi_in, output_layout_strap_lo_in}),
    .sync_out(layout_s)
  );

  assign fault_s = pins_s[7];
  assign sync_level = pins_s[6] | pins_s[5];
  assign sync_edge = sync_level & ~sync_prev_r;
  assign sw_reset = ctrl_r[`PSC_CTRL_SOFT_RESET];
  assign straps_changed = ({pins_s[3:1], layout_s, pins_s[4]} !=
    straps_prev_r);

  // Control select is caught once the synchronised straps have settled
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot_r <= 1'b1;
      settle_r <= 4'h0;
      spi_mode_out <= 1'b0;
    end else if (boot_r) begin
      settle_r <= settle_r + 4'h1;
      if (settle_r == `PSC_STRAP_SETTLE) begin
        boot_r <= 1'b0;
        spi_mode_out <= pins_s[4];
      end
    end
  end

  // Configuration and status; the result readout path never reads these
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      reset_seen_r <= 1'b0;
      need_sync_r <= 1'b1;
      sinc5_sel_out <= 1'b0;
      dec_sel_out <= 2'b00;
      dec_ratio_out <= `PSC_RATIO_00;
      lane_layout_out <= `PSC_LAYOUT_RESET;
      shared_lanes_out <= 1'b0;
      ain_precharge_en_out <= 1'b0;
      ref_precharge_en_out <= 1'b0;
      cfg_apply_out <= 1'b0;
      cfg_valid_out <= 1'b0;
      spi_four_wire_out <= 1'b0;
      sync_cnt_r <= 16'h0000;
      straps_prev_r <= 6'h00;
    end else begin
      sync_prev_r <= sync_level;
      cfg_apply_out <= 1'b0;
      straps_prev_r <= {pins_s[3:1], layout_s, pins_s[4]};
      spi_four_wire_out <= ctrl_r[`PSC_CTRL_SPI_WIRES];
      ain_precharge_en_out <= !spi_mode_out;
      ref_precharge_en_out <= 1'b0;
      if (sw_reset) begin
        reset_seen_r <= 1'b1;
      end
      if (fault_s || sw_reset) begin
        cfg_valid_out <= 1'b0;
        need_sync_r <= 1'b1;
      end else if (!boot_r && !spi_mode_out && straps_changed) begin
        need_sync_r <= 1'b1;
      end
      // Fault and soft reset win over a sync landing in the same cycle
      if (!boot_r && !spi_mode_out && !fault_s && !sw_reset &&
          (sync_edge || sync_req_r)) begin
        sinc5_sel_out <= pins_s[3];
        dec_sel_out <= pins_s[2:1];
        dec_ratio_out <= dec_ratio(pins_s[2:1]);
        lane_layout_out <= layout_s;
        shared_lanes_out <= layout_s != 2'b00;
        cfg_apply_out <= 1'b1;
        cfg_valid_out <= 1'b1;
        need_sync_r <= 1'b0;
        sync_cnt_r <= sync_cnt_r + 16'h0001;
      end
    end
  end

  // Control register; soft reset and sync request self-clear
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `PSC_CTRL_RESET;
      sync_req_r <= 1'b0;
    end else begin
      ctrl_r[`PSC_CTRL_SOFT_RESET] <= 1'b0;
      sync_req_r <= 1'b0;
      if (bus_st_r == ST_ACK && avs_write_in &&
          avs_address_in == `PSC_OFF_CTRL) begin
        ctrl_r[`PSC_CTRL_SOFT_RESET] <=
          avs_writedata_in[`PSC_CTRL_SOFT_RESET];
        ctrl_r[`PSC_CTRL_SPI_WIRES] <=
          avs_writedata_in[`PSC_CTRL_SPI_WIRES];
        sync_req_r <= avs_writedata_in[`PSC_CTRL_SYNC_REQ];
      end
    end
  end

  // Bus slave: one wait cycle, answer on the second edge
  always @* begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      ST_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          bus_st_nxt = ST_ACK;
        end
      end
      ST_ACK: bus_st_nxt = ST_DONE;
      ST_DONE: bus_st_nxt = ST_IDLE;
      default: bus_st_nxt = ST_IDLE;
    endcase
  end

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_in)
      `PSC_OFF_CTRL: begin
        rdata_nxt[`PSC_CTRL_SPI_WIRES] = ctrl_r[`PSC_CTRL_SPI_WIRES];
      end
      `PSC_OFF_STATUS: begin
        rdata_nxt[`PSC_ST_SPI_MODE] = spi_mode_out;
        rdata_nxt[`PSC_ST_RESET_SEEN] = reset_seen_r;
        rdata_nxt[`PSC_ST_NEED_SYNC] = need_sync_r;
        rdata_nxt[`PSC_ST_CFG_VALID] = cfg_valid_out;
        rdata_nxt[`PSC_ST_AIN_PRECHG] = ain_precharge_en_out;
        rdata_nxt[`PSC_ST_REF_PRECHG] = ref_precharge_en_out;
      end
      `PSC_OFF_ACTIVE: begin
        rdata_nxt[`PSC_ACT_FILTER] = sinc5_sel_out;
        rdata_nxt[`PSC_ACT_DEC_LSB+1:`PSC_ACT_DEC_LSB] = dec_sel_out;
        rdata_nxt[`PSC_ACT_RATIO_LSB+10:`PSC_ACT_RATIO_LSB] = dec_ratio_out;
      end
      `PSC_OFF_STRAPS: begin
        rdata_nxt[5:0] = {pins_s[4], pins_s[3], pins_s[2:1], layout_s};
      end
      `PSC_OFF_SYNCCNT: begin
        rdata_nxt[15:0] = sync_cnt_r;
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_r <= ST_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      bus_st_r <= bus_st_nxt;
      avs_waitrequest_out <= !(bus_st_nxt == ST_ACK);
      if (bus_st_nxt == ST_ACK && avs_read_in) begin
        avs_readdata_out <= rdata_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// ===== psc_map.vh
// Register offsets, fields, reset values and timing counts for the strap decoder
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_OFF_CTRL 4'h0
`define PSC_OFF_STATUS 4'h1
`define PSC_OFF_ACTIVE 4'h2
`define PSC_OFF_STRAPS 4'h3
`define PSC_OFF_SYNCCNT 4'h4
`define PSC_CTRL_SOFT_RESET 0
`define PSC_CTRL_SPI_WIRES 1
`define PSC_CTRL_SYNC_REQ 2
`define PSC_CTRL_RESET 32'h0000_0000
`define PSC_ST_SPI_MODE 0
`define PSC_ST_RESET_SEEN 1
`define PSC_ST_NEED_SYNC 2
`define PSC_ST_CFG_VALID 3
`define PSC_ST_AIN_PRECHG 4
`define PSC_ST_REF_PRECHG 5
`define PSC_ACT_FILTER 0
`define PSC_ACT_DEC_LSB 1
`define PSC_ACT_RATIO_LSB 8
`define PSC_RATIO_00 11'h020
`define PSC_RATIO_01 11'h040
`define PSC_RATIO_10 11'h080
`define PSC_RATIO_11 11'h400
`define PSC_LAYOUT_RESET 2'h0
`define PSC_STRAP_SETTLE 4'h3
`endif

// ===== psc_sync2.v
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module psc_sync2 #(
  parameter W = 1
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule
`default_nettype wire

// ===== psc_host_model.sv
// Host model: drives the strap pins and a low sync pulse
`timescale 1ns/1ns
`default_nettype none
module psc_host_model (
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic pulse_in,
  input wire logic [4:0] cfg_in,
  output logic [4:0] straps_out,
  output logic sync_n_out
);
  int n = 0;
  initial straps_out = 5'h0;
  initial sync_n_out = 1'b1;
  // Straps settle well before the pulse so no half-changed code is latched
  always @(posedge ref_clk_in) begin
    if (go_in) begin
      straps_out <= cfg_in;
      n <= 1;
    end else if (n != 0) begin
      n <= (n + 1) % 10;
      sync_n_out <= !(pulse_in && n >= 5 && n < 8);
    end
  end
endmodule
`default_nettype wire

// ===== psc_checker.sv
// Port assertions for the strap decoder
`timescale 1ns/1ns
`default_nettype none
module psc_checker (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sync_n_in,
  input wire logic supply_fault_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic spi_mode_out,
  input wire logic sinc5_sel_out,
  input wire logic [1:0] dec_sel_out,
  input wire logic [10:0] dec_ratio_out,
  input wire logic [1:0] lane_layout_out,
  input wire logic shared_lanes_out,
  input wire logic ain_precharge_en_out,
  input wire logic ref_precharge_en_out,
  input wire logic cfg_apply_out,
  input wire logic cfg_valid_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence pin_sync_s;
    $fell(sync_n_in) && !spi_mode_out && !supply_fault_in;
  endsequence
  sequence latch_s;
    ##[3:5] cfg_apply_out;
  endsequence
  sync_latch_a: assert property (pin_sync_s |-> latch_s)
    else $error("sync pulse not latched");
  cfg_hold_a: assert property (cfg_valid_out && ($changed(dec_sel_out)
    || $changed(sinc5_sel_out)) |-> cfg_apply_out)
    else $error("config moved without sync");
  ratio_map_a: assert property (dec_ratio_out == (dec_sel_out == 2'h3 ?
    11'h400 : 11'h020 << dec_sel_out)) else $error("ratio decode wrong");
  lane_share_a: assert property (shared_lanes_out == (|lane_layout_out))
    else $error("lane sharing wrong");
  ref_off_a: assert property (!ref_precharge_en_out)
    else $error("reference precharge on");
  ain_on_a: assert property (!spi_mode_out [*6] |-> ain_precharge_en_out)
    else $error("input precharge off");
  bus_answer_a: assert property ($rose(avs_read_in || avs_write_in)
    |-> ##[1:3] !avs_waitrequest_out) else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
endmodule
bind psc_strap_decoder psc_checker u_psc_checker (.*);
`default_nettype wire

// ===== psc_strap_decoder_tb_top.sv
// Testbench for the strap decoder
`timescale 1ns/1ns
`default_nettype none
module psc_strap_decoder_tb_top;
  logic ref_clk_in, resetn_in, ctrl_select_strap_in, supply_fault_in;
  logic filter_strap_in, decimation_strap_hi_in, decimation_strap_lo_in;
  logic output_layout_strap_hi_in, output_layout_strap_lo_in;
  logic start_n_in, sync_n_in, avs_read_in, avs_write_in;
  logic [3:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic avs_waitrequest_out, spi_mode_out, spi_four_wire_out, sinc5_sel_out;
  logic [1:0] dec_sel_out, lane_layout_out;
  logic [10:0] dec_ratio_out;
  logic shared_lanes_out, ain_precharge_en_out, ref_precharge_en_out;
  logic cfg_apply_out, cfg_valid_out, go, pulse;
  logic [4:0] cfg, straps;
  logic [10:0] rat [4] = '{11'h020, 11'h040, 11'h080, 11'h400};
  int miscompares = 0;
  int n_checks = 0;
  assign {filter_strap_in, decimation_strap_hi_in, decimation_strap_lo_in,
    output_layout_strap_hi_in, output_layout_strap_lo_in} = straps;
  psc_strap_decoder u_psc_strap_decoder (.*);
  psc_host_model u_psc_host_model (.ref_clk_in(ref_clk_in), .go_in(go),
    .pulse_in(pulse), .cfg_in(cfg), .straps_out(straps),
    .sync_n_out(sync_n_in));
  task automatic chk(input string s, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    k = 0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 40);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (avs_waitrequest_out !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask
  // Fixed wait covers strap settle, pulse and the three-edge latch
  task automatic apply(input logic [4:0] c, input logic p);
    cfg <= c;
    pulse <= p;
    go <= 1'b1;
    @(posedge ref_clk_in);
    go <= 1'b0;
    repeat (14) @(posedge ref_clk_in);
  endtask
  initial forever #20 ref_clk_in = ~ref_clk_in;
  initial begin
    ref_clk_in = 0; resetn_in = 0; ctrl_select_strap_in = 0;
    supply_fault_in = 0; start_n_in = 1; avs_read_in = 0; avs_write_in = 0;
    avs_address_in = 0; avs_writedata_in = 0; go = 0; pulse = 0; cfg = 0;
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    bus(0, 4'h1, 0);
    chk("status", q & 32'h31, 32'h10);
    for (int i = 0; i < 32; i++) begin
      apply(i[4:0], 1'b1);
      chk("filter", sinc5_sel_out, i[4]);
      chk("ratio", dec_ratio_out, rat[i[3:2]]);
      chk("layout", {shared_lanes_out, lane_layout_out}, {|i[1:0], i[1:0]});
      bus(0, 4'h2, 0);
      chk("active", q, {rat[i[3:2]], 5'h0, i[3:2], i[4]});
    end
    apply(5'h00, 1'b0);
    chk("held", {sinc5_sel_out, dec_ratio_out}, {1'b1, 11'h400});
    bus(1, 4'hf, 32'hffff_ffff);
    bus(0, 4'hf, 0);
    chk("unmapped", q, 0);
    supply_fault_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk("fault valid", cfg_valid_out, 0);
    supply_fault_in <= 1'b0;
    apply(5'h04, 1'b1);
    chk("recover", {cfg_valid_out, dec_ratio_out}, {1'b1, 11'h040});
    apply(5'h08, 1'b0);
    bus(1, 4'h0, 32'h4);
    repeat (2) @(posedge ref_clk_in);
    chk("sync request", dec_ratio_out, 11'h080);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h1, 0);
    chk("soft reset", q & 32'h3f, 32'h16);
    resetn_in <= 1'b0;
    ctrl_select_strap_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    chk("spi mode", {spi_mode_out, ain_precharge_en_out}, 2'h2);
    bus(1, 4'h0, 32'h2);
    repeat (2) @(posedge ref_clk_in);
    chk("four wire", spi_four_wire_out, 1);
    bus(1, 4'h0, 0);
    repeat (2) @(posedge ref_clk_in);
    chk("three wire", spi_four_wire_out, 0);
    apply(5'h1f, 1'b1);
    chk("spi ignores sync", dec_ratio_out, 11'h020);
    stop_test();
  end
endmodule
`default_nettype wire
